// >>> design/pxr_receiver.sv
// Pixel receiver: decodes the chain, keeps its colour word, forwards the rest.
`default_nettype none
// Operation
// - Accept primary line data after reset
// - Keep first 24 bits after gap, the next 24 on backup
// - Regenerate and forward every later bit the buffer has room for
// - Forwarded stream is 24 bits shorter, 48 on backup
// - Word order green, red, blue, MSB first
// - 256 grey levels per colour channel
// - Only 300 us low resets frame
// - Watch backup line against primary line
// - Switch to backup when primary silent
// - Backup choice sticks until reset
// - Brightness modulation refreshes at 2 kHz
module pxr_receiver import pxr_pkg::*; #(
  parameter int GAP_CYCLES = GAP_CYC,
  parameter int PWM_STEP = PWM_STEP_CYC,
  parameter int BUF_DEPTH = FIFO_DEPTH,
  parameter int SWITCH_BITS = BKP_SWITCH_BITS
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Serial inputs from upstream.
  input wire logic i_din,
  input wire logic i_backup_serial_input,
  // Regenerated serial output downstream.
  output logic o_dout,
  // Channel drive enables.
  output logic o_led_g,
  output logic o_led_r,
  output logic o_led_b,
  // Displayed grey levels.
  output logic [7:0] o_grn,
  output logic [7:0] o_red,
  output logic [7:0] o_blu,
  // Line supervision.
  output logic o_backup_active,
  output logic o_primary_quiet
);
  localparam int CW = $clog2(GAP_CYCLES + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(GAP_CYCLES);
  localparam logic [CW-1:0] SPLIT = CW'(SPLIT_CYC);
  localparam logic [5:0] OWN_END = 6'(WORD_BITS);
  localparam logic [5:0] SKIP = 6'(BKP_SKIP_BITS);
  localparam int SW = $clog2(SWITCH_BITS + 1);
  localparam int PW = $clog2(PWM_STEP + 1);
  localparam int CHK_ZH1 = ZERO_HI_CYC - 1;
  localparam int CHK_OH1 = ONE_HI_CYC - 1;

  // Refuse settings that the decoder or the dividers cannot serve.
  if (GAP_CYCLES <= 2 * BIT_CYC || PWM_STEP < 1 || SWITCH_BITS < 1) begin : g_bad_param
    $error("pxr_receiver parameters out of range");
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // ---- Line decoders, one per input ----
  logic line_in [2];  // Raw line levels.
  logic prev_reg [2], prev_next [2];  // Level one cycle ago.
  logic [CW-1:0] hi_reg [2], hi_next [2];  // Length of current high pulse.
  logic [CW-1:0] lo_reg [2], lo_next [2];  // Length of current low time.
  logic bit_stb [2];  // A bit ends on the falling edge.
  logic bit_val [2];  // Decoded value of that bit.
  logic gap_stb [2];  // Low time just reached the frame gap.
  logic rise_stb [2];  // Line went high.

  assign line_in[LINE_PRI] = i_din;
  assign line_in[LINE_BKP] = i_backup_serial_input;

  for (genvar k = 0; k < 2; k++) begin : g_dec
    // Measure the high pulse and the low time of each line.
    always_comb begin
      prev_next[k] = line_in[k];
      hi_next[k] = hi_reg[k];
      lo_next[k] = lo_reg[k];
      if (line_in[k]) begin
        lo_next[k] = '0;
        if (!prev_reg[k]) begin
          hi_next[k] = CW'(1);
        end else if (hi_reg[k] != CNT_MAX) begin
          hi_next[k] = hi_reg[k] + 1'b1;
        end
      end else if (lo_reg[k] != CNT_MAX) begin
        lo_next[k] = lo_reg[k] + 1'b1;
      end
    end
    assign rise_stb[k] = line_in[k] && !prev_reg[k];
    assign bit_stb[k] = !line_in[k] && prev_reg[k];
    // A long high pulse is a one, a short one is a zero.
    assign bit_val[k] = (hi_reg[k] >= SPLIT);
    // Only a full gap counts; shorter pauses leave the frame running.
    assign gap_stb[k] = !line_in[k] && (lo_reg[k] == CNT_MAX - 1'b1);
    // Low-time counters start saturated so a quiet line at power-up gives no gap.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        prev_reg[k] <= 1'b0;
        hi_reg[k] <= '0;
        lo_reg[k] <= CNT_MAX;
      end else begin
        prev_reg[k] <= prev_next[k];
        hi_reg[k] <= hi_next[k];
        lo_reg[k] <= lo_next[k];
      end
    end
  end

  // ---- Line supervision ----
  logic use_bkp_reg, use_bkp_next;  // Backup line is the source.
  logic quiet_reg, quiet_next;  // Primary line silent since its last gap.
  logic [SW-1:0] bkp_bits_reg, bkp_bits_next;  // Backup bits seen while quiet.

  // Count backup activity while the primary stays silent, then switch.
  always_comb begin
    use_bkp_next = use_bkp_reg;
    quiet_next = quiet_reg;
    bkp_bits_next = bkp_bits_reg;
    if (rise_stb[LINE_PRI]) begin
      quiet_next = 1'b0;
      bkp_bits_next = '0;
    end else if (gap_stb[LINE_PRI]) begin
      quiet_next = 1'b1;
    end
    if (quiet_reg && !rise_stb[LINE_PRI] && bit_stb[LINE_BKP] &&
        bkp_bits_reg != SW'(SWITCH_BITS)) begin
      bkp_bits_next = bkp_bits_reg + 1'b1;
    end
    if (bkp_bits_reg == SW'(SWITCH_BITS)) begin
      use_bkp_next = 1'b1;
    end
  end

  // Nothing but reset clears the backup choice.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      use_bkp_reg <= 1'b0;
      quiet_reg <= 1'b1;
      bkp_bits_reg <= '0;
    end else begin
      use_bkp_reg <= use_bkp_next;
      quiet_reg <= quiet_next;
      bkp_bits_reg <= bkp_bits_next;
    end
  end

  assign o_backup_active = use_bkp_reg;
  assign o_primary_quiet = quiet_reg;

  // ---- Word capture and forwarding ----
  logic s_bit, s_val, s_gap;  // Events of the selected line.
  logic [5:0] own_start;  // Bits skipped before the own word.
  logic [5:0] bcnt_reg, bcnt_next;  // Bits received in this frame, up to the end of the own word.
  logic [WORD_BITS-1:0] shadow_reg, shadow_next;  // Word being received.
  logic [7:0] grn_reg, grn_next, red_reg, red_next, blu_reg, blu_next;
  logic fwd_phase;  // Own word complete, later bits go downstream.
  logic wr_ready;  // Buffer accepts a bit.
  logic fwd_push;  // Bit handed to the buffer.

  assign s_bit = use_bkp_reg ? bit_stb[LINE_BKP] : bit_stb[LINE_PRI];
  assign s_val = use_bkp_reg ? bit_val[LINE_BKP] : bit_val[LINE_PRI];
  assign s_gap = use_bkp_reg ? gap_stb[LINE_BKP] : gap_stb[LINE_PRI];
  // On the backup line the dead neighbour's word arrives first.
  assign own_start = use_bkp_reg ? SKIP : 6'h00;
  assign fwd_phase = (bcnt_reg == own_start + OWN_END);
  assign fwd_push = s_bit && fwd_phase && wr_ready;

  // Shift in the own word, latch it on a gap, count bits.
  always_comb begin
    bcnt_next = bcnt_reg;
    shadow_next = shadow_reg;
    grn_next = grn_reg;
    red_next = red_reg;
    blu_next = blu_reg;
    if (s_gap) begin
      grn_next = shadow_reg[GRN_LSB +: 8];
      red_next = shadow_reg[RED_LSB +: 8];
      blu_next = shadow_reg[BLU_LSB +: 8];
      bcnt_next = '0;
    end else if (s_bit && !fwd_phase) begin
      bcnt_next = bcnt_reg + 1'b1;
      if (bcnt_reg >= own_start) begin
        shadow_next = {shadow_reg[WORD_BITS-2:0], s_val};
      end
    end
  end

  // Word state registers.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bcnt_reg <= '0;
      shadow_reg <= '0;
      grn_reg <= COLOUR_RST;
      red_reg <= COLOUR_RST;
      blu_reg <= COLOUR_RST;
    end else begin
      bcnt_reg <= bcnt_next;
      shadow_reg <= shadow_next;
      grn_reg <= grn_next;
      red_reg <= red_next;
      blu_reg <= blu_next;
    end
  end

  assign o_grn = grn_reg;
  assign o_red = red_reg;
  assign o_blu = blu_reg;

  // Buffer between the decoded stream and the regenerator.
  logic rd_valid, rd_ready;
  logic [FIFO_WIDTH-1:0] rd_data;
  pxr_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(BUF_DEPTH)) u_fwd_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_wr_valid(s_bit && fwd_phase),
    .o_wr_ready(wr_ready),
    .i_wr_data(FIFO_WIDTH'(s_val)),
    .o_rd_valid(rd_valid),
    .i_rd_ready(rd_ready),
    .o_rd_data(rd_data)
  );

  // ---- Regenerator ----
  pxr_tx_state_t tx_state_reg, tx_state_next;
  logic [7:0] tx_cnt_reg, tx_cnt_next;  // Cycles into the current bit.
  logic tx_bit_reg, tx_bit_next;  // Bit being sent.
  logic dout_reg, dout_next;  // Registered line level.

  assign rd_ready = (tx_state_reg == PXR_TX_IDLE);

  // Send each buffered bit with fixed high and total widths.
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_cnt_next = tx_cnt_reg + 1'b1;
    tx_bit_next = tx_bit_reg;
    unique case (tx_state_reg)
      PXR_TX_IDLE: begin
        tx_cnt_next = '0;
        if (rd_valid) begin
          tx_bit_next = rd_data[0];
          tx_state_next = PXR_TX_HIGH;
        end
      end
      PXR_TX_HIGH: begin
        if (tx_cnt_reg == (tx_bit_reg ? 8'(ONE_HI_CYC - 1) : 8'(ZERO_HI_CYC - 1))) begin
          tx_state_next = PXR_TX_LOW;
        end
      end
      PXR_TX_LOW: begin
        if (tx_cnt_reg == 8'(BIT_CYC - 1)) begin
          tx_state_next = PXR_TX_IDLE;
        end
      end
    endcase
    dout_next = (tx_state_next == PXR_TX_HIGH);
  end

  // Regenerator registers.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_state_reg <= PXR_TX_IDLE;
      tx_cnt_reg <= '0;
      tx_bit_reg <= 1'b0;
      dout_reg <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      dout_reg <= dout_next;
    end
  end

  assign o_dout = dout_reg;

  // ---- Brightness modulation ----
  logic [PW-1:0] step_reg, step_next;  // Divider toward one grey step.
  logic [7:0] level_reg, level_next;  // Ramp over the 256 levels.
  logic step_stb;  // One-cycle enable per grey step.
  logic led_g_reg, led_g_next, led_r_reg, led_r_next, led_b_reg, led_b_next;

  assign step_stb = (step_reg == PW'(PWM_STEP - 1));

  // A full ramp of 256 steps sets the refresh period.
  always_comb begin
    step_next = step_stb ? '0 : step_reg + 1'b1;
    level_next = step_stb ? level_reg + 1'b1 : level_reg;
    led_g_next = (level_reg < grn_reg);
    led_r_next = (level_reg < red_reg);
    led_b_next = (level_reg < blu_reg);
  end

  // Modulation registers.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_reg <= '0;
      level_reg <= 8'h00;
      led_g_reg <= 1'b0;
      led_r_reg <= 1'b0;
      led_b_reg <= 1'b0;
    end else begin
      step_reg <= step_next;
      level_reg <= level_next;
      led_g_reg <= led_g_next;
      led_r_reg <= led_r_next;
      led_b_reg <= led_b_next;
    end
  end

  assign o_led_g = led_g_reg;
  assign o_led_r = led_r_reg;
  assign o_led_b = led_b_reg;

  // ---- Checks ----
  chk_own_not_fwd: assert property (s_bit && !fwd_phase |-> !fwd_push)
    else $error("own bit reached the forward buffer");
  chk_fwd_after_word: assert property (
    s_bit && bcnt_reg == own_start + OWN_END && wr_ready |-> fwd_push)
    else $error("later bit not forwarded");
  chk_fwd_count: assert property (fwd_push |-> bcnt_reg == own_start + 6'd24)
    else $error("forwarding began before 24 own bits");
  chk_latch_word: assert property (
    s_gap |=> o_grn == $past(shadow_reg[23:16]) && o_blu == $past(shadow_reg[7:0]) &&
      bcnt_reg == 6'h00)
    else $error("gap did not latch the colour word");
  chk_gap_length: assert property (s_gap |-> $past(!s_bit, 1) && !s_bit)
    else $error("gap raised during activity");
  chk_bkp_sticky: assert property (use_bkp_reg |=> use_bkp_reg)
    else $error("backup choice was released");
  chk_bkp_cause: assert property ($rose(use_bkp_reg) |-> $past(quiet_reg, 2))
    else $error("switched while the primary line was active");
  chk_zero_width: assert property (
    $rose(o_dout) && !tx_bit_reg |-> ##CHK_ZH1 o_dout ##1 !o_dout)
    else $error("zero pulse width wrong");
  chk_one_width: assert property (
    $rose(o_dout) && tx_bit_reg |-> ##CHK_OH1 o_dout ##1 !o_dout)
    else $error("one pulse width wrong");
  chk_pwm_full: assert property (grn_reg == 8'hFF && level_reg == 8'h00 |=> o_led_g)
    else $error("green drive off at full level");
endmodule
`default_nettype wire

// >>> design/pxr_pkg.sv
// Shared constants for the cascaded pixel serial receiver.
`default_nettype none
package pxr_pkg;
  // Reference clock rate and period.
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_PERIOD_NS = 5;
  // Regenerated pulse widths, chosen inside the legal code windows.
  localparam int ZERO_HI_NS = 350;
  localparam int ONE_HI_NS = 800;
  localparam int BIT_NS = 1100;
  // Decision point between a short and a long high pulse.
  localparam int SPLIT_NS = 615;
  // Low time that marks the end of a frame.
  localparam int GAP_US = 300;
  // Brightness modulation rate and number of grey levels.
  localparam int PWM_HZ = 2000;
  localparam int LEVELS = 256;
  // Derived cycle counts; pulse, bit and gap times round up, modulation counts round down.
  localparam int ZERO_HI_CYC = (ZERO_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ONE_HI_CYC = (ONE_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_CYC = (BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPLIT_CYC = (SPLIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC = (GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
  localparam int PWM_STEP_CYC = PWM_PERIOD_CYC / LEVELS;
  // Colour word layout: green, red, blue, most significant bit first.
  localparam int WORD_BITS = 24;
  localparam int GRN_LSB = 16;
  localparam int RED_LSB = 8;
  localparam int BLU_LSB = 0;
  localparam logic [7:0] COLOUR_RST = 8'h00;
  // Bits of the failed neighbour skipped when running from the backup line.
  localparam int BKP_SKIP_BITS = 24;
  // Backup bits seen while the primary line is quiet before switching over.
  localparam int BKP_SWITCH_BITS = 32;
  // Forwarding buffer shape.
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 1;
  // Line indices of the two receive paths.
  localparam int LINE_PRI = 0;
  localparam int LINE_BKP = 1;
  // Transmit states of the regenerator.
  typedef enum logic [1:0] {
    PXR_TX_IDLE,
    PXR_TX_HIGH,
    PXR_TX_LOW
  } pxr_tx_state_t;
endpackage
`default_nettype wire

// >>> design/pxr_fifo.sv
// Small first-in first-out buffer with a registered read port.
`default_nettype none
module pxr_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Write side.
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  // Read side.
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);

  // Refuse shapes that the pointer arithmetic cannot serve.
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_shape
    $error("pxr_fifo needs a power-of-two depth of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];  // Storage array.
  logic [AW-1:0] wptr_reg, wptr_next;  // Write pointer.
  logic [AW-1:0] rptr_reg, rptr_next;  // Read pointer.
  logic [AW:0] count_reg, count_next;  // Words held in the array.
  logic rd_valid_reg, rd_valid_next;  // Output register holds a word.
  logic [WIDTH-1:0] rd_data_reg, rd_data_next;  // Output register.
  logic push;  // A word enters the array.
  logic pop;  // A word moves to the output register.

  assign o_wr_ready = (count_reg != (AW + 1)'(DEPTH));
  assign push = i_wr_valid && o_wr_ready;
  assign pop = (count_reg != '0) && (!rd_valid_reg || i_rd_ready);
  assign o_rd_valid = rd_valid_reg;
  assign o_rd_data = rd_data_reg;

  // Next pointers, fill level and output stage.
  always_comb begin
    wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
    rptr_next = pop ? rptr_reg + 1'b1 : rptr_reg;
    count_next = count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    rd_data_next = pop ? mem[rptr_reg] : rd_data_reg;
    if (pop) begin
      rd_valid_next = 1'b1;
    end else if (i_rd_ready) begin
      rd_valid_next = 1'b0;
    end else begin
      rd_valid_next = rd_valid_reg;
    end
  end

  // Storage is written without reset; only its pointers, count and output register need one.
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wptr_reg] <= i_wr_data;
    end
  end

  // Control and output registers.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      count_reg <= count_next;
      rd_valid_reg <= rd_valid_next;
      rd_data_reg <= rd_data_next;
    end
  end
endmodule
`default_nettype wire

// >>> bench/pxr_sender.sv
// Upstream sender model that drives one serial line of the pixel chain.
`default_nettype none
module pxr_sender (
  // Clock used only to time the pulses.
  input wire logic i_ref_clk,
  // Driven serial line, idle low between frames.
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // High and low widths in cycles for nominal, slow and over-rate timing (mode 0, 1, 2).
  int zero_hi[3] = '{70, 90, 40};
  int zero_lo[3] = '{180, 180, 40};
  int one_hi[3] = '{170, 190, 130};
  int one_lo[3] = '{80, 80, 20};
  // The line rests low until the first frame.
  initial o_line = 1'b0;
  // Sends the n lowest bits of w, highest first; the caller stands at a falling edge.
  task automatic send_bits(input logic [63:0] w, input int n, input int mode);
    int hi;
    int lo;
    for (int i = n - 1; i >= 0; i--) begin
      hi = w[i] ? one_hi[mode] : zero_hi[mode];
      lo = w[i] ? one_lo[mode] : zero_lo[mode];
      o_line = 1'b1;
      repeat (hi) @(negedge i_ref_clk);
      o_line = 1'b0;
      repeat (lo) @(negedge i_ref_clk);
    end
  endtask
  // Holds the line low; a long hold ends the frame, a short one is a pause.
  task automatic hold_low(input int n);
    o_line = 1'b0;
    repeat (n) @(negedge i_ref_clk);
  endtask
endmodule
`default_nettype wire

// >>> bench/pxr_receiver_test.sv
// Self-checking testbench for the pixel receiver with two upstream sender models.
`default_nettype none
module pxr_receiver_test import pxr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Shortened frame gap and modulation step, so one modulation period is 1024 cycles.
  localparam int GAP_SIM = 600;
  localparam int STEP_SIM = 4;
  // Clock, reset and lines.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pri_line;
  logic bkp_line;
  // Design outputs.
  logic dout, led_g, led_r, led_b, bkp_act, pri_quiet;
  logic [7:0] grn, red, blu;
  // Counters, expected forwarded bits and the flag that suspends pulse comparison.
  int miscompares = 0;
  int n_compared = 0;
  int fwd_cnt = 0;
  int hw = 0;
  bit ignore = 1'b0;
  logic exp_q[$];
  // The clock toggles every half period of 5 ns.
  always #2.5 clk = ~clk;
  // Primary and backup upstream senders.
  pxr_sender pri_u (.i_ref_clk(clk), .o_line(pri_line));
  pxr_sender bkp_u (.i_ref_clk(clk), .o_line(bkp_line));
  // Receiver under test with shortened counts.
  pxr_receiver #(.GAP_CYCLES(GAP_SIM), .PWM_STEP(STEP_SIM)) dut_u (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_din(pri_line), .i_backup_serial_input(bkp_line),
    .o_dout(dout), .o_led_g(led_g), .o_led_r(led_r), .o_led_b(led_b),
    .o_grn(grn), .o_red(red), .o_blu(blu),
    .o_backup_active(bkp_act), .o_primary_quiet(pri_quiet));
  // Compares one value and reports a difference at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: %s saw %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("Counts: %0d compared, %0d mismatches", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Checks the three displayed grey levels against one colour word.
  task automatic check_colours(input logic [23:0] w);
    check(32'(grn), 32'(w[23:16]), "green");
    check(32'(red), 32'(w[15:8]), "red");
    check(32'(blu), 32'(w[7:0]), "blue");
  endtask
  // Notes the bits expected on the forward output, highest first.
  task automatic expect_bits(input logic [63:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) exp_q.push_back(w[i]);
  endtask
  // Waits, bounded, until the forward output has rested low for 300 cycles.
  task automatic wait_idle();
    int low_run;
    low_run = 0;
    for (int k = 0; k < 20000 && low_run < 300; k++) begin
      @(negedge clk);
      low_run = (dout === 1'b0) ? low_run + 1 : 0;
    end
    if (low_run < 300) begin
      check(0, 1, "forward output never idled");
      close_out();
    end
  endtask
  // Measures each forwarded pulse away from the edge that launches it.
  always @(negedge clk) begin
    if (rst_n !== 1'b1) begin
      hw = 0;
    end else if (dout === 1'b1) begin
      hw++;
    end else if (hw > 0) begin
      fwd_cnt++;
      if (!ignore) begin
        if (exp_q.size() == 0) check(32'(hw), 0, "unexpected forwarded pulse");
        else check(32'(hw), exp_q.pop_front() ? ONE_HI_CYC : ZERO_HI_CYC, "pulse");
      end
      hw = 0;
    end
  end
  // Cuts a hung run short.
  initial begin
    repeat (98000) @(posedge clk);
    check(0, 1, "run too long");
    close_out();
  end
  // Main sequence of scenarios.
  initial begin
    logic [23:0] w;
    logic [23:0] p;
    logic [23:0] a;
    logic [7:0] f;
    int c_g;
    int c_r;
    int c_b;
    void'($urandom(32'h8D76));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    // Values straight after reset.
    check_colours(24'h000000);
    check(32'(bkp_act), 0, "backup active");
    check(32'(pri_quiet), 1, "primary quiet");
    $display("Test reset values done");
    // A frame of an own word and a forwarded word.
    w = 24'($urandom);
    a = 24'($urandom);
    expect_bits(64'(a), 24);
    pri_u.send_bits({w, a}, 48, 0);
    check(32'(pri_quiet), 0, "primary quiet while active");
    pri_u.hold_low(700);
    wait_idle();
    check_colours(w);
    check(32'(exp_q.size()), 0, "bits left unforwarded");
    $display("Test frame forwarding done");
    // Duty of each channel over one full modulation period.
    c_g = 0;
    c_r = 0;
    c_b = 0;
    repeat (LEVELS * STEP_SIM) begin
      @(posedge clk);
      c_g += int'(led_g === 1'b1);
      c_r += int'(led_r === 1'b1);
      c_b += int'(led_b === 1'b1);
    end
    @(negedge clk);
    check(32'(c_g), 32'({w[23:16], 2'b00}), "green duty");
    check(32'(c_r), 32'({w[15:8], 2'b00}), "red duty");
    check(32'(c_b), 32'({w[7:0], 2'b00}), "blue duty");
    $display("Test modulation done");
    // A short pause in the middle of the own word must not end the frame.
    p = w;
    w = 24'($urandom);
    pri_u.send_bits(64'(w[23:12]), 12, 1);
    pri_u.hold_low(GAP_SIM - 300);
    check_colours(p);
    pri_u.send_bits(64'(w[11:0]), 12, 1);
    pri_u.hold_low(700);
    check_colours(w);
    $display("Test short pause done");
    // Over-rate burst fills the forwarding buffer until it drops bits.
    ignore = 1'b1;
    fwd_cnt = 0;
    pri_u.send_bits(64'h0, 24, 2);
    pri_u.send_bits(64'h0, 35, 2);
    pri_u.send_bits(64'h0, 35, 2);
    pri_u.hold_low(700);
    wait_idle();
    check(32'(fwd_cnt >= 33 && fwd_cnt < 64), 1, "forwarded count after burst");
    check_colours(24'h000000);
    ignore = 1'b0;
    $display("Test buffer overflow done");
    // Primary silent: backup traffic takes over.
    ignore = 1'b1;
    bkp_u.send_bits({$urandom, $urandom}, 40, 1);
    bkp_u.hold_low(700);
    check(32'(bkp_act), 1, "backup active after switch");
    wait_idle();
    ignore = 1'b0;
    a = 24'($urandom);
    w = 24'($urandom);
    f = 8'($urandom);
    expect_bits(64'(f), 8);
    bkp_u.send_bits(64'({a, w, f}), 56, 1);
    bkp_u.hold_low(700);
    wait_idle();
    check_colours(w);
    check(32'(exp_q.size()), 0, "backup bits left unforwarded");
    $display("Test backup switch done");
    // The backup choice sticks when the primary line returns.
    pri_u.send_bits({$urandom, $urandom}, 48, 0);
    pri_u.hold_low(700);
    check(32'(bkp_act), 1, "backup still active");
    check_colours(w);
    $display("Test backup sticky done");
    // A reset in mid-run returns to the primary line.
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    check(32'(bkp_act), 0, "backup after reset");
    check_colours(24'h000000);
    rst_n = 1'b1;
    @(negedge clk);
    w = 24'($urandom);
    pri_u.send_bits(64'(w), 24, 0);
    pri_u.hold_low(700);
    check_colours(w);
    $display("Test second reset done");
    close_out();
  end
endmodule
`default_nettype wire
